// ### esr_pkg.sv
// package: register map, field positions, reset values and timing constants
// Operation
// R1: remote loop sends received line data to transmit outputs; framer still sees it
// R2: local loop replaces line receive data with transmit data, through jitter path
// R3: line all-ones bit forces unframed ones on line transmit outputs
// R4: two five-bit monitor selects choose transmit and receive monitored channels
// R5: host writes zero to the two unassigned bits of the line-reset register
// R6: status and information bits latch high until read; synchronizer register excluded
// R7: read clears a latched bit, but persistent alarms stay set while present
// R8: mask write updates read value where mask is one, holds where zero
// R9: host does mask write, read, then write-back of read value and mask
// R10: synchronizer register is read-only, unlatched, real time, needs no mask write
// R11: interrupt mask bits enable, one, or mask, zero, each status cause
// R12: four persistent alarms interrupt on every change of state, cleared by read
// R13: other causes interrupt when the event occurs, cleared by read
// R14: elastic store empty and full flags set on frame repeat or delete
// R15: jitter limit flag sets within four bits of attenuator limit
// R16: frame resync flag sets after three consecutive bad alignment words
// R17: signaling multiframe resync flag sets after two consecutive bad alignment words
// R18: six-bit search counter counts 8 ms timeouts, wraps, clears on sync or disable
// R19: synchronizer shows frame, signaling multiframe and crc multiframe search flags
// R20: all-zeros timeslot 16 sets zeros flag; signaling change sets both flags
// R21: receive slip flag sets on receive store repeat or delete
// R22: carrier loss after 255 zeros, or 2048 with alternate criterion
// R23: host toggles line reset bit 0 to 1 and waits about 40 ms
// R24: far-end alarm sets on three ones, clears on three zeros of bit 3
// R25: unframed-ones alarm sets under three zeros per 512 bits, clears otherwise
// R26: carrier loss clears on at least 32 ones within 255 bits
// R27: interrupt stays low while any unmasked cause pends
package esr_pkg;
   localparam logic [7:0] ADDR_ALARM_STATUS = 8'h06;
   localparam logic [7:0] ADDR_EVENT_STATUS = 8'h07;
   localparam logic [7:0] ADDR_RX_INFO = 8'h08;
   localparam logic [7:0] ADDR_ALARM_MASK = 8'h16;
   localparam logic [7:0] ADDR_EVENT_MASK = 8'h17;
   localparam logic [7:0] ADDR_SYNC_STATE = 8'h1E;
   localparam logic [7:0] ADDR_LOOP_CTRL = 8'hA8;
   localparam logic [7:0] ADDR_LINE_CTRL = 8'hAA;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int BIT_REMOTE_LOOP = 7;
   localparam int BIT_LOCAL_LOOP = 6;
   localparam int BIT_ALL_ONES = 5;
   localparam int BIT_LINE_RESET = 7;
   // alarm status positions that persist while alarm present
   localparam logic [7:0] PERSIST_MASK = 8'hEF;
   // alarms interrupting on change of state: unframed ones, far end, carrier, sync
   localparam logic [7:0] CHANGE_MASK = 8'h0F;
   localparam int FAR_END_RUN = 3;
   localparam int FRAME_RESYNC_RUN = 3;
   localparam int SIG_RESYNC_RUN = 2;
   localparam int LOS_ZEROS = 255;
   localparam int LOS_ZEROS_ALT = 2048;
   localparam int LOS_WINDOW = 255;
   localparam int LOS_CLEAR_ONES = 32;
   localparam int UA1_WINDOW = 512;
   localparam int UA1_ZEROS = 3;
   localparam int JITTER_MARGIN = 4;
   localparam int SEARCH_TIMEOUT_MS = 8;
   localparam int CLK_MHZ = 100;
   localparam int SEARCH_CYCLES = SEARCH_TIMEOUT_MS * 1000 * CLK_MHZ;
endpackage

// ### esr_latch_reg.sv
// one latched status register with mask-write read image
`timescale 1ns/1ps
module esr_latch_reg (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [7:0] event_i,
   input wire logic [7:0] persist_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] latched_o,
   output logic [7:0] image_o
);
   logic [7:0] latched_q;
   logic [7:0] image_q;
   logic [7:0] clr_q;
   assign latched_o = latched_q;
   assign image_o = image_q;
   // the read clears the image bits, and any write clears bits set in both it and the previous write; set still wins
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         latched_q <= esr_pkg::RESET_BYTE;
      end else begin
         latched_q <= (latched_q & ~((rd_i ? image_q : 8'h00) | (wr_i ? (wdata_i & clr_q) : 8'h00)))
            | event_i | persist_i; // [R6] [R7]
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         image_q <= esr_pkg::RESET_BYTE;
         clr_q <= esr_pkg::RESET_BYTE;
      end else if (wr_i) begin
         image_q <= (wdata_i & latched_q) | (~wdata_i & image_q); // [R8]
         clr_q <= wdata_i;
      end
   end
   a_set_wins: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R6]
      (event_i != 8'h00) |=> ((latched_q & $past(event_i)) == $past(event_i)))
      else $error("latched event bit lost");
   a_persist_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R7]
      (persist_i != 8'h00) |=> ((latched_q & $past(persist_i)) == $past(persist_i)))
      else $error("persistent alarm bit dropped");
   a_mask_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R8]
      wr_i |=> ((image_q & ~$past(wdata_i)) == ($past(image_q) & ~$past(wdata_i))))
      else $error("masked image bit changed");
endmodule

// ### esr_alarm_det.sv
// receive line alarm detectors: carrier loss, unframed ones, far end alarm
`timescale 1ns/1ps
module esr_alarm_det (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic bit_valid_i,
   input wire logic bit_i,
   input wire logic alt_los_i,
   input wire logic nas_valid_i,
   input wire logic nas_bit3_i,
   output logic carrier_loss_o,
   output logic unframed_ones_o,
   output logic far_end_o
);
   logic [11:0] zrun_q;
   logic [7:0] win_q;
   logic [5:0] ones_q;
   logic [9:0] uwin_q;
   logic [1:0] uzero_q;
   logic [1:0] fcnt_q;
   logic los_q;
   logic ua_q;
   logic fe_q;
   assign carrier_loss_o = los_q;
   assign unframed_ones_o = ua_q;
   assign far_end_o = fe_q;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         zrun_q <= 12'h000;
         win_q <= 8'h00;
         ones_q <= 6'h00;
         los_q <= 1'b0;
      end else if (bit_valid_i) begin
         zrun_q <= bit_i ? 12'h000 : (zrun_q == 12'hFFF ? zrun_q : zrun_q + 12'h001);
         if (!los_q && !bit_i && (zrun_q + 12'h001) >= (alt_los_i ? 12'(esr_pkg::LOS_ZEROS_ALT)
               : 12'(esr_pkg::LOS_ZEROS))) begin
            los_q <= 1'b1; // [R22]
            win_q <= 8'h00;
            ones_q <= 6'h00;
         end else if (los_q) begin
            if (ones_q + 6'(bit_i) >= 6'(esr_pkg::LOS_CLEAR_ONES)) begin
               los_q <= 1'b0; // [R26]
            end
            if (win_q == 8'(esr_pkg::LOS_WINDOW - 1)) begin
               win_q <= 8'h00;
               ones_q <= 6'h00;
            end else begin
               win_q <= win_q + 8'h01;
               ones_q <= (ones_q == 6'h3F) ? ones_q : ones_q + 6'(bit_i);
            end
         end
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         uwin_q <= 10'h000;
         uzero_q <= 2'h0;
         ua_q <= 1'b0;
      end else if (bit_valid_i) begin
         if (uwin_q == 10'(esr_pkg::UA1_WINDOW - 1)) begin
            ua_q <= (uzero_q + 2'(!bit_i && uzero_q != 2'h3)) < 2'(esr_pkg::UA1_ZEROS); // [R25]
            uwin_q <= 10'h000;
            uzero_q <= 2'h0;
         end else begin
            uwin_q <= uwin_q + 10'h001;
            uzero_q <= (uzero_q == 2'h3) ? uzero_q : uzero_q + 2'(!bit_i);
         end
      end
   end
   // run counter toward the opposite state of the alarm
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         fcnt_q <= 2'h0;
         fe_q <= 1'b0;
      end else if (nas_valid_i) begin
         if (nas_bit3_i == fe_q) begin
            fcnt_q <= 2'h0;
         end else if (fcnt_q == 2'(esr_pkg::FAR_END_RUN - 1)) begin
            fe_q <= nas_bit3_i; // [R24]
            fcnt_q <= 2'h0;
         end else begin
            fcnt_q <= fcnt_q + 2'h1;
         end
      end
   end
   a_far_end_run: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R24]
      $rose(fe_q) |-> $past(nas_valid_i) && $past(nas_bit3_i) && $past(fcnt_q) == 2'h2)
      else $error("far end alarm set without three ones");
   a_los_cause: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R22]
      $rose(los_q) |-> $past(zrun_q) >= 12'd254)
      else $error("carrier loss set too early");
endmodule

// ### esr_regs.sv
// status, alarm, loopback and monitor registers on the parallel control port
`timescale 1ns/1ps
module esr_regs (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic int_n_o,
   input wire logic rx_pos_in_i,
   input wire logic rx_neg_in_i,
   input wire logic line_tx_pos_in_i,
   input wire logic line_tx_neg_in_i,
   input wire logic line_rx_tip_i,
   input wire logic line_rx_ring_i,
   output logic tx_pos_out_o,
   output logic tx_neg_out_o,
   output logic line_tx_tip_o,
   output logic line_tx_ring_o,
   output logic framer_rx_pos_o,
   output logic framer_rx_neg_o,
   output logic jitter_loop_sel_o,
   output logic line_interface_reset_o,
   input wire logic [7:0] tx_channel_data_i,
   input wire logic [4:0] tx_channel_num_i,
   input wire logic [7:0] rx_channel_data_i,
   input wire logic [4:0] rx_channel_num_i,
   output logic [7:0] tx_monitor_data_reg_o,
   output logic [7:0] rx_monitor_data_reg_o,
   input wire logic line_bit_valid_i,
   input wire logic alt_carrier_i,
   input wire logic nas_valid_i,
   input wire logic nas_bit3_i,
   input wire logic sig_ones_i,
   input wire logic sig_zero_mf_i,
   input wire logic sig_change_i,
   input wire logic distant_mf_i,
   input wire logic sync_lost_i,
   input wire logic rx_slip_i,
   input wire logic [7:0] event_i,
   input wire logic tx_store_full_i,
   input wire logic tx_store_empty_i,
   input wire logic jitter_depth_near_i,
   input wire logic rx_store_full_i,
   input wire logic rx_store_empty_i,
   input wire logic crc_resync_i,
   input wire logic fas_word_valid_i,
   input wire logic fas_word_err_i,
   input wire logic cas_word_valid_i,
   input wire logic cas_word_err_i,
   input wire logic crc_rx_enable_i,
   input wire logic crc_sync_i,
   input wire logic frame_search_active_i,
   input wire logic sig_multiframe_search_active_i,
   input wire logic crc_multiframe_search_active_i
);
   logic [7:0] loop_ctrl_q;
   logic [7:0] line_ctrl_q;
   logic [7:0] alarm_mask_q;
   logic [7:0] event_mask_q;
   logic [7:0] rdata_q;
   logic int_n_q;
   logic tx_pos_q, tx_neg_q, tip_q, ring_q, fr_pos_q, fr_neg_q;
   logic [7:0] tx_mon_q, rx_mon_q;
   logic [1:0] fas_run_q;
   logic cas_run_q;
   logic [5:0] search_cnt_q;
   logic [26:0] search_tmr_q;
   logic [2:0] sync_q;
   logic [3:0] chg_prev_q;
   logic [7:0] pend_alarm_q, pend_event_q;
   logic los_w, ua_w, fe_w;
   logic fas_trip, cas_trip, search_to;
   logic [7:0] alarm_ev, alarm_persist, info_ev;
   logic [7:0] alarm_lat, alarm_img, event_lat, event_img, info_lat, info_img;
   logic wr_alarm, wr_event, wr_info, rd_alarm, rd_event, rd_info;
   assign wr_alarm = wr_i && addr_i == esr_pkg::ADDR_ALARM_STATUS;
   assign wr_event = wr_i && addr_i == esr_pkg::ADDR_EVENT_STATUS;
   assign wr_info = wr_i && addr_i == esr_pkg::ADDR_RX_INFO;
   assign rd_alarm = rd_i && addr_i == esr_pkg::ADDR_ALARM_STATUS;
   assign rd_event = rd_i && addr_i == esr_pkg::ADDR_EVENT_STATUS;
   assign rd_info = rd_i && addr_i == esr_pkg::ADDR_RX_INFO;
   esr_alarm_det u_det (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .bit_valid_i(line_bit_valid_i),
      .bit_i(line_rx_tip_i | line_rx_ring_i),
      .alt_los_i(alt_carrier_i),
      .nas_valid_i(nas_valid_i),
      .nas_bit3_i(nas_bit3_i),
      .carrier_loss_o(los_w),
      .unframed_ones_o(ua_w),
      .far_end_o(fe_w)
   );
   // signaling change sets both ones and zeros flags
   assign alarm_persist = {sig_ones_i, distant_mf_i, sig_zero_mf_i, 1'b0, ua_w, fe_w, los_w, sync_lost_i}
      & esr_pkg::PERSIST_MASK; // [R7] [R20]
   assign alarm_ev = {sig_change_i, 2'b00, 1'b0, 4'h0} | {2'b00, sig_change_i, rx_slip_i, 4'h0}; // [R20] [R21]
   assign fas_trip = fas_word_valid_i && fas_word_err_i && fas_run_q == 2'(esr_pkg::FRAME_RESYNC_RUN - 1);
   assign cas_trip = cas_word_valid_i && cas_word_err_i && cas_run_q;
   assign info_ev = {tx_store_full_i, tx_store_empty_i, jitter_depth_near_i, rx_store_full_i,
      rx_store_empty_i, crc_resync_i, fas_trip, cas_trip}; // [R14] [R15] [R16] [R17]
   esr_latch_reg u_alarm (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .event_i(alarm_ev), .persist_i(alarm_persist),
      .wr_i(wr_alarm), .rd_i(rd_alarm), .wdata_i(wdata_i), .latched_o(alarm_lat), .image_o(alarm_img)
   );
   esr_latch_reg u_event (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .event_i(event_i), .persist_i(8'h00),
      .wr_i(wr_event), .rd_i(rd_event), .wdata_i(wdata_i), .latched_o(event_lat), .image_o(event_img)
   );
   esr_latch_reg u_info (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .event_i(info_ev), .persist_i(8'h00),
      .wr_i(wr_info), .rd_i(rd_info), .wdata_i(wdata_i), .latched_o(info_lat), .image_o(info_img)
   );
   // consecutive alignment word error runs
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         fas_run_q <= 2'h0;
         cas_run_q <= 1'b0;
      end else begin
         if (fas_word_valid_i) begin
            fas_run_q <= (fas_word_err_i && !fas_trip) ? fas_run_q + 2'h1 : 2'h0; // [R16]
         end
         if (cas_word_valid_i) begin
            cas_run_q <= cas_word_err_i && !cas_run_q; // [R17]
         end
      end
   end
   assign search_to = crc_multiframe_search_active_i && search_tmr_q == 27'(esr_pkg::SEARCH_CYCLES - 1);
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         search_tmr_q <= 27'h0;
         search_cnt_q <= 6'h00;
      end else begin
         search_tmr_q <= (!crc_multiframe_search_active_i || search_to) ? 27'h0 : search_tmr_q + 27'h1;
         if (!crc_rx_enable_i || crc_sync_i) begin
            search_cnt_q <= 6'h00; // [R18]
         end else if (search_to) begin
            search_cnt_q <= search_cnt_q + 6'h01; // [R18]
         end
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= {frame_search_active_i, sig_multiframe_search_active_i,
            crc_multiframe_search_active_i}; // [R19]
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         loop_ctrl_q <= esr_pkg::RESET_BYTE;
         line_ctrl_q <= esr_pkg::RESET_BYTE;
         alarm_mask_q <= esr_pkg::RESET_BYTE;
         event_mask_q <= esr_pkg::RESET_BYTE;
      end else if (wr_i) begin
         case (addr_i)
            esr_pkg::ADDR_LOOP_CTRL: loop_ctrl_q <= wdata_i;
            esr_pkg::ADDR_LINE_CTRL: line_ctrl_q <= wdata_i; // host keeps bits 6:5 zero [R5]
            esr_pkg::ADDR_ALARM_MASK: alarm_mask_q <= wdata_i;
            esr_pkg::ADDR_EVENT_MASK: event_mask_q <= wdata_i;
            default: ;
         endcase
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rdata_q <= esr_pkg::RESET_BYTE;
      end else if (rd_i) begin
         case (addr_i)
            esr_pkg::ADDR_ALARM_STATUS: rdata_q <= alarm_img;
            esr_pkg::ADDR_EVENT_STATUS: rdata_q <= event_img;
            esr_pkg::ADDR_RX_INFO: rdata_q <= info_img;
            esr_pkg::ADDR_SYNC_STATE: rdata_q <= {search_cnt_q[5:2], search_cnt_q[0], sync_q}; // [R10] [R18]
            esr_pkg::ADDR_ALARM_MASK: rdata_q <= alarm_mask_q;
            esr_pkg::ADDR_EVENT_MASK: rdata_q <= event_mask_q;
            esr_pkg::ADDR_LOOP_CTRL: rdata_q <= loop_ctrl_q;
            esr_pkg::ADDR_LINE_CTRL: rdata_q <= line_ctrl_q;
            default: rdata_q <= 8'h00;
         endcase
      end
   end
   assign rdata_o = rdata_q;
   // interrupt pending: change-of-state for four alarms, event or present alarm input for the rest
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         chg_prev_q <= 4'h0;
         pend_alarm_q <= 8'h00;
         pend_event_q <= 8'h00;
         int_n_q <= 1'b1;
      end else begin
         chg_prev_q <= alarm_persist[3:0];
         pend_alarm_q <= (pend_alarm_q & ~(rd_alarm ? alarm_img : 8'h00))
            | ({4'h0, alarm_persist[3:0] ^ chg_prev_q} & esr_pkg::CHANGE_MASK) // [R12]
            | (alarm_ev | (alarm_persist & ~esr_pkg::CHANGE_MASK)); // [R13]
         pend_event_q <= (pend_event_q & ~(rd_event ? event_img : 8'h00)) | event_i; // [R13]
         int_n_q <= ~(|(pend_alarm_q & alarm_mask_q) | |(pend_event_q & event_mask_q)); // [R11] [R27]
      end
   end
   assign int_n_o = int_n_q;
   // line paths, registered to keep outputs on flip-flops
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         tx_pos_q <= 1'b0;
         tx_neg_q <= 1'b0;
         tip_q <= 1'b0;
         ring_q <= 1'b0;
         fr_pos_q <= 1'b0;
         fr_neg_q <= 1'b0;
      end else begin
         tx_pos_q <= loop_ctrl_q[esr_pkg::BIT_REMOTE_LOOP] ? rx_pos_in_i : line_tx_pos_in_i; // [R1]
         tx_neg_q <= loop_ctrl_q[esr_pkg::BIT_REMOTE_LOOP] ? rx_neg_in_i : line_tx_neg_in_i; // [R1]
         // all ones: tip and ring both forced high in the same cycle, no alternation
         tip_q <= loop_ctrl_q[esr_pkg::BIT_ALL_ONES] ? 1'b1 : tx_pos_q; // [R3]
         ring_q <= loop_ctrl_q[esr_pkg::BIT_ALL_ONES] ? 1'b1 : tx_neg_q; // [R3]
         fr_pos_q <= loop_ctrl_q[esr_pkg::BIT_LOCAL_LOOP] ? tx_pos_q : rx_pos_in_i; // [R2]
         fr_neg_q <= loop_ctrl_q[esr_pkg::BIT_LOCAL_LOOP] ? tx_neg_q : rx_neg_in_i; // [R2]
      end
   end
   assign tx_pos_out_o = tx_pos_q;
   assign tx_neg_out_o = tx_neg_q;
   assign line_tx_tip_o = tip_q;
   assign line_tx_ring_o = ring_q;
   assign framer_rx_pos_o = fr_pos_q;
   assign framer_rx_neg_o = fr_neg_q;
   assign jitter_loop_sel_o = loop_ctrl_q[esr_pkg::BIT_LOCAL_LOOP]; // [R2]
   assign line_interface_reset_o = line_ctrl_q[esr_pkg::BIT_LINE_RESET];
   // channel monitors capture selected channel byte
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         tx_mon_q <= 8'h00;
         rx_mon_q <= 8'h00;
      end else begin
         if (tx_channel_num_i == loop_ctrl_q[4:0]) begin
            tx_mon_q <= tx_channel_data_i; // [R4]
         end
         if (rx_channel_num_i == line_ctrl_q[4:0]) begin
            rx_mon_q <= rx_channel_data_i; // [R4]
         end
      end
   end
   assign tx_monitor_data_reg_o = tx_mon_q;
   assign rx_monitor_data_reg_o = rx_mon_q;
   a_int_release: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R27]
      ((pend_alarm_q & alarm_mask_q) == 8'h00 && (pend_event_q & event_mask_q) == 8'h00) |=> int_n_q)
      else $error("interrupt held with nothing pending");
   a_int_assert: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R11]
      (|(pend_event_q & event_mask_q)) |=> !int_n_q)
      else $error("unmasked event did not interrupt");
   a_remote_loop: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R1]
      loop_ctrl_q[esr_pkg::BIT_REMOTE_LOOP] |=> tx_pos_q == $past(rx_pos_in_i))
      else $error("remote loop data mismatch");
   a_local_loop: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R2]
      loop_ctrl_q[esr_pkg::BIT_LOCAL_LOOP] |=> fr_pos_q == $past(tx_pos_q))
      else $error("local loop data mismatch");
   a_all_ones: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R3]
      loop_ctrl_q[esr_pkg::BIT_ALL_ONES] |=> tip_q && ring_q)
      else $error("all ones not forced");
   a_crc_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R18]
      !crc_rx_enable_i |=> search_cnt_q == 6'h00)
      else $error("search counter not cleared");
   a_change_int: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R12]
      (alarm_persist[3:0] != chg_prev_q) |=> ((pend_alarm_q[3:0] & $past(alarm_persist[3:0] ^ chg_prev_q))
      == $past(alarm_persist[3:0] ^ chg_prev_q)))
      else $error("alarm change not pending");
endmodule

// ### esr_host_model.sv
// host model: byte access tasks on the parallel control port
`timescale 1ns/1ps
module esr_host_model (
   input wire logic ref_clk_i,
   input wire logic [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] wdata_o
);
   initial begin
      {addr_o, wr_o, rd_o, wdata_o} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      #1;
      addr_o = a;
      wdata_o = (a == 8'hAA) ? (v & 8'h9F) : v;
      wr_o = 1'b1;
      @(posedge ref_clk_i);
      #1;
      wr_o = 1'b0;
      // a released bus shows the inverse, never a stale value
      {addr_o, wdata_o} = ~{addr_o, wdata_o};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk_i);
      #1;
      addr_o = a;
      rd_o = 1'b1;
      @(posedge ref_clk_i);
      #1;
      rd_o = 1'b0;
      addr_o = ~addr_o;
      v = rdata_i;
   endtask
   // write-read-write so events landing mid-poll are not lost
   task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] v);
      wr(a, m);
      rd(a, v);
      wr(a, v & m);
   endtask
endmodule

// ### esr_regs_tb.sv
// self-checking bench for the status, alarm and loopback registers
`timescale 1ns/1ps
module esr_regs_tb;
   bit reset_i = 1'b1;
   bit rx_pos_in_i, rx_neg_in_i, line_tx_pos_in_i, line_tx_neg_in_i, line_rx_tip_i, line_rx_ring_i;
   bit line_bit_valid_i, alt_carrier_i, nas_valid_i, nas_bit3_i, sig_ones_i, sig_zero_mf_i, sig_change_i;
   bit distant_mf_i, sync_lost_i, rx_slip_i, fas_word_valid_i, fas_word_err_i, cas_word_valid_i, cas_word_err_i;
   bit crc_rx_enable_i, crc_sync_i, frame_search_active_i, sig_multiframe_search_active_i;
   bit crc_multiframe_search_active_i;
   bit [7:0] event_i;
   bit [5:0] ri;
   bit [25:0] ch;
   logic ref_clk_i, wr_i, rd_i, int_n_o, tx_pos_out_o, tx_neg_out_o, line_tx_tip_o, line_tx_ring_o;
   logic framer_rx_pos_o, framer_rx_neg_o, jitter_loop_sel_o, line_interface_reset_o, tx_store_full_i;
   logic tx_store_empty_i, jitter_depth_near_i, rx_store_full_i, rx_store_empty_i, crc_resync_i;
   logic [7:0] addr_i, wdata_i, rdata_o, tx_monitor_data_reg_o, rx_monitor_data_reg_o, d;
   logic [7:0] tx_channel_data_i, rx_channel_data_i;
   logic [4:0] tx_channel_num_i, rx_channel_num_i;
   int mismatches, samples_checked;
   assign {tx_store_full_i, tx_store_empty_i, jitter_depth_near_i} = ri[5:3];
   assign {rx_store_full_i, rx_store_empty_i, crc_resync_i} = ri[2:0];
   assign {tx_channel_num_i, tx_channel_data_i, rx_channel_num_i, rx_channel_data_i} = ch;
   esr_regs uut (.*);
   esr_host_model h (.ref_clk_i(ref_clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i),
      .wdata_o(wdata_i));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic ci(input logic e);
      chk({7'h00, int_n_o}, {7'h00, e});
   endtask
   task automatic aw(input logic [1:0] e);
      {fas_word_valid_i, cas_word_valid_i, fas_word_err_i, cas_word_err_i} = {2'b11, e};
      tick(1);
      {fas_word_valid_i, cas_word_valid_i, fas_word_err_i, cas_word_err_i} = '0;
      tick(1);
   endtask
   task automatic nas(input logic b, input int n);
      repeat (n) begin
         {nas_valid_i, nas_bit3_i} = {1'b1, b};
         tick(1);
         nas_valid_i = 1'b0;
         tick(1);
      end
   endtask
   initial begin
      tick(12);
      reset_i = 1'b0;
      h.rd(8'hA8, d);
      chk(d, esr_pkg::RESET_BYTE);
      h.rd(8'h55, d);
      chk(d, 8'h00);
      ci(1'b1);
      {rx_pos_in_i, rx_neg_in_i} = 2'b11;
      h.wr(8'hA8, 8'h80);
      tick(4);
      chk({4'h0, tx_pos_out_o, framer_rx_pos_o, tx_neg_out_o, framer_rx_neg_o}, 8'h0F);
      {rx_pos_in_i, line_tx_pos_in_i} = 2'b01;
      h.wr(8'hA8, 8'h40);
      tick(4);
      chk({4'h0, jitter_loop_sel_o, tx_pos_out_o, framer_rx_pos_o, framer_rx_neg_o}, 8'h0E);
      line_tx_pos_in_i = 1'b0;
      h.wr(8'hAA, 8'hF3);
      h.wr(8'hA8, 8'h25);
      tick(4);
      chk({6'h00, line_tx_tip_o, line_tx_ring_o}, 8'h03);
      chk({7'h00, line_interface_reset_o}, 8'h01);
      h.rd(8'hAA, d);
      chk(d, 8'h93);
      ch = {5'd5, 8'hA5, 5'd19, 8'h3C};
      tick(1);
      ch = {5'd6, 8'h5A, 5'd20, 8'hC3};
      tick(2);
      chk(tx_monitor_data_reg_o, 8'hA5);
      chk(rx_monitor_data_reg_o, 8'h3C);
      h.wr(8'h17, 8'h01);
      event_i = 8'h03;
      tick(1);
      event_i = 8'h00;
      tick(3);
      ci(1'b0);
      h.poll(8'h07, 8'h01, d);
      chk(d, 8'h01);
      tick(3);
      ci(1'b1);
      h.poll(8'h07, 8'h02, d);
      chk(d, 8'h02);
      h.poll(8'h07, 8'hFF, d);
      chk(d, 8'h00);
      for (int i = 0; i < 6; i++) begin
         ri = 6'h20 >> i;
         tick(1);
         ri = 6'h00;
         h.poll(8'h08, 8'hFF, d);
         chk(d, 8'h80 >> i);
      end
      // a good word between errors must restart the run
      aw(2'b11);
      aw(2'b10);
      h.poll(8'h08, 8'hFF, d);
      chk(d, 8'h00);
      aw(2'b11);
      h.poll(8'h08, 8'hFF, d);
      chk(d, 8'h02);
      aw(2'b01);
      h.poll(8'h08, 8'hFF, d);
      chk(d, 8'h01);
      {frame_search_active_i, sig_multiframe_search_active_i, crc_multiframe_search_active_i} = 3'b101;
      tick(2);
      h.rd(8'h1E, d);
      chk(d, 8'h05);
      {frame_search_active_i, sig_multiframe_search_active_i, crc_multiframe_search_active_i} = 3'b010;
      h.wr(8'h1E, 8'hFF);
      h.rd(8'h1E, d);
      chk(d, 8'h02);
      h.wr(8'h16, 8'h14);
      nas(1'b1, 2);
      tick(3);
      ci(1'b1);
      nas(1'b1, 1);
      tick(3);
      ci(1'b0);
      h.poll(8'h06, 8'h04, d);
      chk(d, 8'h04);
      h.poll(8'h06, 8'h04, d);
      chk(d, 8'h04);
      tick(3);
      ci(1'b1);
      nas(1'b0, 3);
      tick(3);
      ci(1'b0);
      h.poll(8'h06, 8'h04, d);
      h.poll(8'h06, 8'h04, d);
      chk(d, 8'h00);
      rx_slip_i = 1'b1;
      tick(1);
      rx_slip_i = 1'b0;
      tick(3);
      ci(1'b0);
      h.poll(8'h06, 8'h10, d);
      chk(d, 8'h10);
      tick(3);
      ci(1'b1);
      sig_change_i = 1'b1;
      tick(1);
      sig_change_i = 1'b0;
      h.poll(8'h06, 8'hA0, d);
      chk(d, 8'hA0);
      // zeros on the line pins until carrier loss, then ones until it clears
      line_bit_valid_i = 1'b1;
      tick(260);
      h.poll(8'h06, 8'h02, d);
      chk(d, 8'h02);
      line_rx_tip_i = 1'b1;
      tick(40);
      line_bit_valid_i = 1'b0;
      h.poll(8'h06, 8'h02, d);
      h.poll(8'h06, 8'h02, d);
      chk(d, 8'h00);
      print_verdict();
   end
endmodule
